// *** rtl/ppi_map.svh ***
`ifndef PPI_MAP_SVH
`define PPI_MAP_SVH

// ----------------------------------------------------------------
// Clock and time base
// ----------------------------------------------------------------
`define PPI_CLK_NS 5
`define PPI_NS_PER_MS 1000000
`define PPI_CYC_PER_MS (`PPI_NS_PER_MS / `PPI_CLK_NS)

// ----------------------------------------------------------------
// Power sequencing and indicator timing, in milliseconds
// ----------------------------------------------------------------
`define PPI_ON_DLY_MS 9'h00a
`define PPI_BLINK_MS 9'h1f4
`define PPI_MS_ONE 9'h001

// ----------------------------------------------------------------
// Serial port and storage layout
// ----------------------------------------------------------------
`define PPI_I2C_ADDR 7'h50
`define PPI_EE_DEPTH 16
`define PPI_EE_AW 4
`define PPI_PTR_ONE 4'h1
`define PPI_BYTE_BITS 4'h8
`define PPI_LAST_BIT 4'h7
`define PPI_CNT_ONE 4'h1
`define PPI_MSB 7
`define PPI_NEXT_MSB 6

`endif

// *** rtl/ppi_pkg.sv ***
`include "ppi_map.svh"

package ppi_pkg;

    // ------------------------------------------------------------
    // Main output sequencing states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PPI_OFF = 2'b00,
        PPI_WAIT = 2'b01,
        PPI_ON = 2'b10
    } ppi_pwr_t;

    // ------------------------------------------------------------
    // Serial slave states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PPI_I_IDLE = 3'b000,
        PPI_I_ADDR = 3'b001,
        PPI_I_ACKA = 3'b010,
        PPI_I_WR = 3'b011,
        PPI_I_ACKW = 3'b100,
        PPI_I_RD = 3'b101,
        PPI_I_ACKR = 3'b110
    } ppi_i2c_t;

    // Pin inputs, all asynchronous to sys_clk
    typedef struct packed {
        logic main_en_n;
        logic in_power_ok;
        logic over_voltage_trip;
        logic short_circuit_trip;
        logic over_current_trip;
        logic temp_high;
        logic temp_ok;
        logic fan_fail;
        logic under_voltage_trip;
        logic in_over_voltage;
        logic redundant;
        logic unit_in_fail;
        logic sec_rail_fault;
        logic standby_short;
        logic temp_warn;
        logic general_fail;
        logic scl;
        logic sda;
    } ppi_pins_t;

    // Whole state of the top module, less the synchroniser and tick divider flops
    typedef struct packed {
        ppi_pwr_t pst;
        logic [8:0] dly;
        logic prot_latch;
        logic otp;
        logic main_on;
        logic sb_on;
        logic [8:0] blink_cnt;
        logic blink;
        logic pwr_g;
        logic pwr_o;
        logic brd_g;
        logic buzz;
        logic ttl;
        logic alert_o;
        logic alert_oe;
        logic scl_d;
        logic sda_d;
        ppi_i2c_t ist;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic first;
        logic more;
        logic [`PPI_EE_AW-1:0] ptr;
        logic sda_oe;
        logic [`PPI_EE_DEPTH-1:0][7:0] mem;
    } ppi_state_t;

endpackage

// *** rtl/ppi_sync.sv ***
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Two-stage synchroniser for a bundle of pin levels
// ----------------------------------------------------------------
module ppi_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk, // System clock
    input wire logic nrst, // Synchronous reset, active low
    input wire logic [W-1:0] d, // Asynchronous levels
    output logic [W-1:0] q // Synchronised levels
);

    logic [W-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule // ppi_sync

// *** rtl/ppi_tick.sv ***
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Divider giving a one-cycle enable pulse every DIV cycles
// ----------------------------------------------------------------
module ppi_tick #(
    parameter int unsigned DIV = 200000
) (
    input wire logic sys_clk, // System clock
    input wire logic nrst, // Synchronous reset, active low
    output logic tick // One-cycle enable pulse
);

    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
    logic [W-1:0] cnt_r;

    // Free-running count, so the phase is arbitrary
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            cnt_r <= '0;
            tick <= 1'h0;
        end
        else if (cnt_r == W'(DIV - 1))
        begin
            cnt_r <= '0;
            tick <= 1'h1;
        end
        else
        begin
            cnt_r <= cnt_r + W'(1);
            tick <= 1'h0;
        end
    end

endmodule // ppi_tick

// *** rtl/ppi_top.sv ***
`timescale 1ns/10ps
`include "ppi_map.svh"

module ppi_top #(
    parameter int unsigned CYC_PER_MS = `PPI_CYC_PER_MS,
    parameter logic [6:0] DEV_ADDR = `PPI_I2C_ADDR
) (
    input wire logic sys_clk, // 200 MHz clock
    input wire logic nrst, // Synchronous reset, active low
    input wire ppi_pkg::ppi_pins_t pins, // Asynchronous pin inputs
    output logic main_on, // Main rails enabled
    output logic standby_rail_on, // Standby rail enabled
    output logic pwr_led_green, // Power LED green
    output logic pwr_led_orange, // Power LED orange
    output logic board_led_green, // Board LED green
    output logic buzzer, // Buzzer alarm
    output logic fault_ttl, // Optional fault line
    output logic alert_o, // Alert pin level when driven
    output logic alert_oe, // Alert pin drive enable
    output logic sda_o, // Serial data level when driven
    output logic sda_oe // Serial data drive enable
);

    // ------------------------------------------------------------
    // Input synchronisation and time base
    // ------------------------------------------------------------
    ppi_pkg::ppi_pins_t s;
    ppi_pkg::ppi_state_t q;
    ppi_pkg::ppi_state_t n;
    logic ms_tick;

    ppi_sync #(
        .W($bits(ppi_pkg::ppi_pins_t))
    ) u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .d(pins),
        .q(s)
    );

    ppi_tick #(
        .DIV(CYC_PER_MS)
    ) u_tick (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .tick(ms_tick)
    );

    // ------------------------------------------------------------
    // Derived conditions
    // ------------------------------------------------------------
    logic release_req;
    logic latch_trip;
    logic stop_main;
    logic sup_fault;
    logic in_fault;
    logic alert_ev;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;

    // Host release or loss of input power frees the latch
    assign release_req = s.main_en_n | ~s.in_power_ok;
    // Faults that latch the main rails off
    assign latch_trip = s.over_voltage_trip | s.short_circuit_trip
        | s.over_current_trip;
    // Anything that keeps or forces the main rails off
    assign stop_main = release_req | q.prot_latch | latch_trip
        | q.otp | s.temp_high;
    // Faults of the supply itself
    assign sup_fault = s.over_voltage_trip | q.otp | s.fan_fail;
    assign in_fault = s.under_voltage_trip | s.in_over_voltage;
    // Events that report to the system on the alert line
    assign alert_ev = s.temp_warn | s.general_fail
        | s.over_current_trip | s.over_voltage_trip
        | in_fault | s.fan_fail;

    // Edges from the synchronised levels and their delayed copy
    assign scl_rise = s.scl & ~q.scl_d;
    assign scl_fall = ~s.scl & q.scl_d;
    assign start_c = s.scl & q.scl_d & q.sda_d & ~s.sda;
    assign stop_c = s.scl & q.scl_d & ~q.sda_d & s.sda;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        n = q;
        n.scl_d = s.scl;
        n.sda_d = s.sda;

        // Set wins over release, so a live fault is never lost
        n.prot_latch = latch_trip
            | (q.prot_latch & ~release_req);

        // Trip above high mark, recover only below the low mark
        if (s.temp_high)
        begin
            n.otp = 1'h1;
        end
        else if (s.temp_ok)
        begin
            n.otp = 1'h0;
        end

        // Main rail sequencing
        case (q.pst)
            ppi_pkg::PPI_OFF:
            begin
                n.dly = '0;
                if (!stop_main)
                begin
                    n.pst = ppi_pkg::PPI_WAIT;
                end
            end
            ppi_pkg::PPI_WAIT:
            begin
                if (stop_main)
                begin
                    n.pst = ppi_pkg::PPI_OFF;
                end
                else if (ms_tick)
                begin
                    n.dly = q.dly + `PPI_MS_ONE;
                    // Tick phase is free, so the on delay lands between 9 and 10 ms
                    if (n.dly == `PPI_ON_DLY_MS)
                    begin
                        n.pst = ppi_pkg::PPI_ON;
                    end
                end
            end
            ppi_pkg::PPI_ON:
            begin
                if (stop_main)
                begin
                    n.pst = ppi_pkg::PPI_OFF;
                end
            end
            default:
            begin
                n.pst = ppi_pkg::PPI_OFF;
            end
        endcase
        n.main_on = (n.pst == ppi_pkg::PPI_ON);

        // Standby never latches; it follows the short directly
        n.sb_on = ~s.standby_short;

        // Blink phase, half period in milliseconds
        if (ms_tick)
        begin
            if (q.blink_cnt == (`PPI_BLINK_MS - `PPI_MS_ONE))
            begin
                n.blink_cnt = '0;
                n.blink = ~q.blink;
            end
            else
            begin
                n.blink_cnt = q.blink_cnt + `PPI_MS_ONE;
            end
        end

        // Indicator map, highest priority first; the next state is used
        // so the fault line and solid green never lag or lead main_on
        n.pwr_g = 1'h1;
        n.pwr_o = 1'h0;
        n.brd_g = 1'h1;
        n.buzz = 1'h0;
        n.ttl = 1'h0;
        if (in_fault)
        begin
            n.pwr_g = 1'h0;
            n.pwr_o = 1'h1;
            n.brd_g = 1'h0;
        end
        else if (s.redundant && s.unit_in_fail)
        begin
            n.pwr_g = 1'h0;
            n.pwr_o = 1'h1;
            n.brd_g = q.blink;
            n.buzz = 1'h1;
        end
        else if (sup_fault || (!s.redundant
            && (s.over_current_trip || q.prot_latch)))
        begin
            n.pwr_g = 1'h0;
            n.pwr_o = 1'h1;
            n.brd_g = q.blink;
            n.buzz = s.redundant;
        end
        else if (s.sec_rail_fault || s.over_current_trip
            || q.prot_latch)
        begin
            n.pwr_g = q.blink;
            n.brd_g = q.blink;
        end
        else if (n.pst != ppi_pkg::PPI_ON)
        begin
            n.pwr_g = q.blink;
            n.brd_g = q.blink;
        end
        else
        begin
            n.ttl = s.redundant;
        end

        // Alert is pulled low with the orange indicator
        n.alert_o = 1'h0;
        n.alert_oe = alert_ev | n.pwr_o;

        // Serial slave; clock is never driven here
        if (start_c)
        begin
            n.ist = ppi_pkg::PPI_I_ADDR;
            n.cnt = '0;
            n.sda_oe = 1'h0;
        end
        else if (stop_c)
        begin
            n.ist = ppi_pkg::PPI_I_IDLE;
            n.sda_oe = 1'h0;
        end
        else
        begin
            case (q.ist)
                ppi_pkg::PPI_I_IDLE:
                begin
                    n.sda_oe = 1'h0;
                end
                ppi_pkg::PPI_I_ADDR:
                begin
                    if (scl_rise)
                    begin
                        n.sh = {q.sh[`PPI_NEXT_MSB:0], s.sda};
                        n.cnt = q.cnt + `PPI_CNT_ONE;
                    end
                    else if (scl_fall && q.cnt == `PPI_BYTE_BITS)
                    begin
                        n.cnt = '0;
                        // Other addresses are left alone
                        if (q.sh[`PPI_MSB:1] == DEV_ADDR)
                        begin
                            n.rw = q.sh[0];
                            n.sda_oe = 1'h1;
                            n.ist = ppi_pkg::PPI_I_ACKA;
                        end
                        else
                        begin
                            n.ist = ppi_pkg::PPI_I_IDLE;
                        end
                    end
                end
                ppi_pkg::PPI_I_ACKA:
                begin
                    if (scl_fall && q.rw)
                    begin
                        n.sh = q.mem[q.ptr];
                        n.sda_oe = ~q.mem[q.ptr][`PPI_MSB];
                        n.cnt = '0;
                        n.ist = ppi_pkg::PPI_I_RD;
                    end
                    else if (scl_fall)
                    begin
                        n.sda_oe = 1'h0;
                        n.first = 1'h1;
                        n.cnt = '0;
                        n.ist = ppi_pkg::PPI_I_WR;
                    end
                end
                ppi_pkg::PPI_I_WR:
                begin
                    if (scl_rise)
                    begin
                        n.sh = {q.sh[`PPI_NEXT_MSB:0], s.sda};
                        n.cnt = q.cnt + `PPI_CNT_ONE;
                    end
                    else if (scl_fall && q.cnt == `PPI_BYTE_BITS)
                    begin
                        // First byte after the address is the pointer
                        if (q.first)
                        begin
                            n.ptr = q.sh[`PPI_EE_AW-1:0];
                        end
                        else
                        begin
                            n.mem[q.ptr] = q.sh;
                            n.ptr = q.ptr + `PPI_PTR_ONE;
                        end
                        n.first = 1'h0;
                        n.sda_oe = 1'h1;
                        n.ist = ppi_pkg::PPI_I_ACKW;
                    end
                end
                ppi_pkg::PPI_I_ACKW:
                begin
                    if (scl_fall)
                    begin
                        n.sda_oe = 1'h0;
                        n.cnt = '0;
                        n.ist = ppi_pkg::PPI_I_WR;
                    end
                end
                ppi_pkg::PPI_I_RD:
                begin
                    if (scl_fall && q.cnt == `PPI_LAST_BIT)
                    begin
                        n.sda_oe = 1'h0;
                        n.ptr = q.ptr + `PPI_PTR_ONE;
                        n.ist = ppi_pkg::PPI_I_ACKR;
                    end
                    else if (scl_fall)
                    begin
                        n.cnt = q.cnt + `PPI_CNT_ONE;
                        n.sh = {q.sh[`PPI_NEXT_MSB:0], 1'h0};
                        n.sda_oe = ~q.sh[`PPI_NEXT_MSB];
                    end
                end
                ppi_pkg::PPI_I_ACKR:
                begin
                    if (scl_rise)
                    begin
                        n.more = ~s.sda;
                    end
                    else if (scl_fall && q.more)
                    begin
                        n.sh = q.mem[q.ptr];
                        n.sda_oe = ~q.mem[q.ptr][`PPI_MSB];
                        n.cnt = '0;
                        n.ist = ppi_pkg::PPI_I_RD;
                    end
                    else if (scl_fall)
                    begin
                        n.ist = ppi_pkg::PPI_I_IDLE;
                    end
                end
                default:
                begin
                    n.ist = ppi_pkg::PPI_I_IDLE;
                    n.sda_oe = 1'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Storage is volatile flops and clears on reset
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            q <= '0;
        end
        else
        begin
            q <= n;
        end
    end

    // ------------------------------------------------------------
    // Outputs, each straight from the state register except sda_o, tied low
    // ------------------------------------------------------------
    assign main_on = q.main_on;
    assign standby_rail_on = q.sb_on;
    assign pwr_led_green = q.pwr_g;
    assign pwr_led_orange = q.pwr_o;
    assign board_led_green = q.brd_g;
    assign buzzer = q.buzz;
    assign fault_ttl = q.ttl;
    assign alert_o = q.alert_o;
    assign alert_oe = q.alert_oe;
    assign sda_o = 1'h0;
    assign sda_oe = q.sda_oe;

endmodule // ppi_top

// *** verification/ppi_host.sv ***
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Host side: serial master, pull-ups on data and alert
// ----------------------------------------------------------------
module ppi_host #(
    parameter int HALF = 20,
    parameter int GAP = 20
) (
    input wire logic sys_clk, // System clock
    input wire logic sda_oe, // Device pulls data low
    input wire logic alert_oe, // Device pulls alert low
    output logic scl, // Serial clock
    output logic sda, // Data wire level
    output logic alert_n // Alert wire level
);
    logic drv_low = 1'b0;
    // Pull-ups: a released wire reads high
    assign sda = !(drv_low || sda_oe);
    assign alert_n = !alert_oe;
    initial scl = 1'b1;
    // Half bit; slow against sys_clk as the port's rate limit demands
    task automatic hb();
        repeat (HALF) @(negedge sys_clk);
    endtask
    // Start, repeatable: data falls while the clock is high
    task automatic start();
        scl = 1'b0;
        hb();
        drv_low = 1'b0;
        hb();
        scl = 1'b1;
        hb();
        drv_low = 1'b1;
        hb();
    endtask
    // Stop, then the command spacing
    task automatic stop();
        scl = 1'b0;
        hb();
        drv_low = 1'b1;
        hb();
        scl = 1'b1;
        hb();
        drv_low = 1'b0;
        repeat (GAP) hb();
    endtask
    // One bit out, wire sampled with the clock high
    task automatic bit_io(input logic b, output logic s);
        scl = 1'b0;
        hb();
        drv_low = !b;
        hb();
        scl = 1'b1;
        hb();
        s = sda;
    endtask
    // Byte MSB first then acknowledge bit; all ones releases the wire
    task automatic xfer(input logic [7:0] w, input logic last,
        output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(w[i], r[i]);
        bit_io(last, ack);
    endtask
endmodule // ppi_host

// *** verification/ppi_top_properties.sv ***
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Protection, indicator and alert checks
// ----------------------------------------------------------------
module ppi_top_properties #(
    parameter int unsigned CYC_PER_MS = 200000
) (
    input wire logic sys_clk, // System clock
    input wire logic nrst, // Reset, active low
    input wire ppi_pkg::ppi_pins_t pins, // Pin inputs
    input wire logic main_on, // Main rails
    input wire logic standby_rail_on, // Standby rail
    input wire logic pwr_led_green, // Power LED green
    input wire logic pwr_led_orange, // Power LED orange
    input wire logic board_led_green, // Board LED
    input wire logic buzzer, // Buzzer
    input wire logic fault_ttl, // Fault line
    input wire logic alert_o, // Alert level
    input wire logic alert_oe, // Alert drive
    input wire logic sda_o, // Data level
    input wire logic sda_oe // Data drive
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    int en_low_r;
    logic warn;
    // Any event that must pull the alert line
    assign warn = pins.temp_warn || pins.general_fail || pins.fan_fail
        || pins.over_current_trip || pins.over_voltage_trip
        || pins.under_voltage_trip || pins.in_over_voltage;
    // Enable low time; saturates so a long run cannot wrap it
    always_ff @(posedge sys_clk)
    begin
        if (!nrst || pins.main_en_n)
            en_low_r <= 0;
        else if (en_low_r < 1000000)
            en_low_r <= en_low_r + 1;
    end
    // Four samples cover the two sync flops and the state register
    sequence s_trip;
        (pins.over_voltage_trip || pins.short_circuit_trip
            || pins.over_current_trip) [*4];
    endsequence
    sequence s_in_bad;
        (pins.under_voltage_trip || pins.in_over_voltage) [*4];
    endsequence
    sequence s_unit_loss;
        (pins.redundant && pins.unit_in_fail && !pins.under_voltage_trip
            && !pins.in_over_voltage) [*4];
    endsequence
    a_trip_kills_main: assert property (s_trip |=> !main_on)
        else $error("main on during trip");
    a_hot_kills_main: assert property (pins.temp_high [*4] |=> !main_on)
        else $error("main on while hot");
    a_enable_off: assert property (pins.main_en_n [*4] |=> !main_on)
        else $error("main on with enable high");
    a_on_delay: assert property ($rose(main_on) |-> en_low_r >= 5 * CYC_PER_MS)
        else $error("main on too early");
    a_standby_back: assert property (!pins.standby_short [*4] |=> standby_rail_on)
        else $error("standby rail off");
    a_input_fault: assert property (s_in_bad |=> pwr_led_orange
        && !board_led_green && !buzzer && !fault_ttl)
        else $error("input fault indication wrong");
    a_unit_loss: assert property (s_unit_loss |=> pwr_led_orange && buzzer)
        else $error("unit loss indication wrong");
    a_alert_raise: assert property (warn [*4] |=> alert_oe && !alert_o)
        else $error("alert not raised");
    a_alert_quiet: assert property (!warn [*4] |=> pwr_led_orange || !alert_oe)
        else $error("alert raised without cause");
    a_alert_orange: assert property (pwr_led_orange |-> alert_oe)
        else $error("orange without alert");
    a_ttl_normal: assert property (fault_ttl |-> main_on && pwr_led_green
        && board_led_green && !buzzer)
        else $error("fault line high off normal");
    a_sda_only_low: assert property (sda_oe |-> !sda_o)
        else $error("data driven high");
endmodule // ppi_top_properties

bind ppi_top ppi_top_properties #(.CYC_PER_MS(CYC_PER_MS)) u_props (
    .sys_clk, .nrst, .pins, .main_on, .standby_rail_on, .pwr_led_green,
    .pwr_led_orange, .board_led_green, .buzzer, .fault_ttl, .alert_o,
    .alert_oe, .sda_o, .sda_oe
);

// *** verification/psu_protection_indicator_tb.sv ***
`timescale 1ns/10ps

`define CHK(nm, ex, got) \
    begin \
        total_checks++; \
        if ((got) !== (ex)) \
        begin \
            fails++; \
            $display("mismatch %s exp %h got %h", nm, ex, got); \
        end \
    end

// ----------------------------------------------------------------
// Protection and indicator bench
// ----------------------------------------------------------------
module psu_protection_indicator_tb;
    localparam int CPM = 20;
    localparam logic [6:0] ADR = 7'h50; // Arbitrary bus address
    localparam logic [17:0] BASE = 18'h10803;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    ppi_pkg::ppi_pins_t p = BASE;
    ppi_pkg::ppi_pins_t pw;
    logic main_on, standby_rail_on, pwr_led_green, pwr_led_orange;
    logic board_led_green, buzzer, fault_ttl, alert_o, alert_oe;
    logic sda_o, sda_oe, scl, sda, alert_n;
    int fails = 0;
    int total_checks = 0;
    // Fault masks and {orange, buzzer, fault line, alert}
    logic [17:0] msk [18] = '{18'h00000, 18'h00080, 18'h08000, 18'h08080,
        18'h01800, 18'h00400, 18'h00480, 18'h00200, 18'h00100, 18'h000c0,
        18'h000a0, 18'h02000, 18'h02080, 18'h00008, 18'h00004, 18'h20080,
        18'h04000, 18'h00280};
    logic [3:0] want [18] = '{4'h0, 4'h2, 4'h9, 4'hd, 4'h9, 4'h9, 4'hd,
        4'h9, 4'h9, 4'hd, 4'h0, 4'h9, 4'h1, 4'h1, 4'h1, 4'h0, 4'h9, 4'h9};
    assign pw = {p[17:2], scl, sda};

    initial forever #2.5 sys_clk = ~sys_clk;

    ppi_top #(.CYC_PER_MS(CPM), .DEV_ADDR(ADR)) uut (
        .sys_clk, .nrst, .pins(pw), .main_on, .standby_rail_on,
        .pwr_led_green, .pwr_led_orange, .board_led_green, .buzzer,
        .fault_ttl, .alert_o, .alert_oe, .sda_o, .sda_oe
    );
    ppi_host #(.HALF(20), .GAP(CPM)) host (
        .sys_clk, .sda_oe, .alert_oe, .scl, .sda, .alert_n
    );

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // Bounded wait for the main rails
    task automatic wait_on(output int n);
        n = 0;
        while (main_on !== 1'b1 && n < 400)
        begin
            @(negedge sys_clk);
            n++;
        end
    endtask
    // Enable toggle, the host's way of clearing a latched shutdown
    task automatic toggle();
        p.main_en_n = 1'b1;
        cyc(6);
        p.main_en_n = 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Hang guard, several times the expected run
    initial
    begin
        repeat (60000) @(posedge sys_clk);
        fails++;
        tally_and_finish();
    end

    initial
    begin
        int n;
        logic [7:0] r;
        logic a;
        cyc(5);
        `CHK("reset outs", 3'b000, {main_on, alert_oe, sda_oe})
        nrst = 1'b1;
        wait_on(n);
        `CHK("on delay", 1'b1, n >= 9 * CPM && n <= 10 * CPM + 8)
        `CHK("normal", 3'b111, {pwr_led_green, board_led_green, standby_rail_on})
        p.main_en_n = 1'b1;
        cyc(4);
        `CHK("off delay", 1'b0, main_on)
        p.main_en_n = 1'b0;
        wait_on(n);
        $display("sequencing test done");
        for (int i = 0; i < 18; i++)
        begin
            p = BASE ^ msk[i];
            cyc(6);
            `CHK("indication", want[i], {pwr_led_orange, buzzer, fault_ttl, alert_oe})
            `CHK("alert pin", !want[i][0], alert_n)
            p = BASE;
            toggle();
            wait_on(n);
            $display("row %0d done", i);
        end
        p.over_voltage_trip = 1'b1;
        cyc(2);
        p.over_voltage_trip = 1'b0;
        cyc(300);
        `CHK("latched off", 1'b0, main_on)
        p.in_power_ok = 1'b0;
        cyc(4);
        p.in_power_ok = 1'b1;
        wait_on(n);
        `CHK("power cycle release", 1'b1, main_on)
        $display("latch test done");
        p.temp_high = 1'b1;
        p.temp_ok = 1'b0;
        cyc(6);
        `CHK("hot", 2'b01, {main_on, standby_rail_on})
        p.temp_high = 1'b0;
        cyc(300);
        `CHK("hysteresis band", 1'b0, main_on)
        p.temp_ok = 1'b1;
        wait_on(n);
        `CHK("auto restore", 2'b11, {main_on, standby_rail_on})
        p.standby_short = 1'b1;
        cyc(6);
        `CHK("standby short", 1'b0, standby_rail_on)
        p.standby_short = 1'b0;
        cyc(6);
        `CHK("standby back", 1'b1, standby_rail_on)
        $display("temperature and standby test done");
        host.start();
        host.xfer({ADR, 1'b0}, 1'b1, r, a);
        `CHK("addr ack", 1'b0, a)
        host.xfer(8'h03, 1'b1, r, a);
        host.xfer(8'ha5, 1'b1, r, a);
        host.xfer(8'h3c, 1'b1, r, a);
        `CHK("data ack", 1'b0, a)
        host.stop();
        host.start();
        host.xfer({ADR, 1'b0}, 1'b1, r, a);
        host.xfer(8'h03, 1'b1, r, a);
        host.stop();
        host.start();
        host.xfer({ADR, 1'b1}, 1'b1, r, a);
        host.xfer(8'hff, 1'b0, r, a);
        `CHK("read first", 8'ha5, r)
        host.xfer(8'hff, 1'b1, r, a);
        `CHK("read next", 8'h3c, r)
        host.stop();
        host.start();
        host.xfer({ADR ^ 7'h01, 1'b0}, 1'b1, r, a);
        `CHK("foreign addr", 1'b1, a)
        host.stop();
        $display("serial test done");
        tally_and_finish();
    end
endmodule // psu_protection_indicator_tb
